/* File: rotate_pkg.sv */
// constants and operation codes for the byte rotate unit
// assumes the core decodes instructions into rotOp_t codes
package rotate_pkg;
	localparam int DATA_WIDTH = 8;
	localparam int TOP_BIT = 7;
	localparam int BOTTOM_BIT = 0;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic CARRY_RESET = 1'b0;
	// execution slot: result is registered one cycle after the request
	localparam int EXEC_CYCLES = 1;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_ROTATE_LEFT_IN_PLACE,
		OP_ROTATE_LEFT_TO_ACCUMULATOR,
		OP_ROTATE_LEFT_VIA_CARRY_IN_PLACE,
		OP_ROTATE_LEFT_VIA_CARRY_TO_ACCUMULATOR,
		OP_ROTATE_RIGHT_IN_PLACE,
		OP_ROTATE_RIGHT_TO_ACCUMULATOR
	} rotOp_t;
endpackage

/* File: rotate_shifter.sv */
// combinational one-bit rotator for one byte
// assumes the caller picks the fill bit (wrap or carry)
`timescale 1ns/1ps
module rotate_shifter
	import rotate_pkg::*;
(
	input wire logic [7:0] operand,
	input wire logic toLeft,
	input wire logic fillBit,
	output logic [7:0] rotated,
	output logic outBit
);
	always_comb begin
		if (toLeft) begin
			rotated = {operand[TOP_BIT-1:BOTTOM_BIT], fillBit};
			outBit = operand[TOP_BIT];
		end else begin
			rotated = {fillBit, operand[TOP_BIT:BOTTOM_BIT+1]};
			outBit = operand[BOTTOM_BIT];
		end
	end
endmodule // rotate_shifter

/* File: byte_rotate_unit.sv */
// single-bit rotate datapath for an 8-bit core
// assumes the operand byte is valid with opValid; results appear one cycle later
//
// Operation
// RQ1: left in place: bits up one, bit 7 to bit 0, memory written, flags kept.
// RQ2: rotate left to accumulator: wrapped left rotate into accumulator, flags kept.
// RQ3: accumulator-destination rotates never write the memory byte.
// RQ4: left via carry in place: carry into bit 0, bit 7 to carry, memory written.
// RQ5: left via carry to accumulator: carry into bit 0, bit 7 to carry.
// RQ6: rotate right in place: bits down one, bit 0 to bit 7, flags kept.
// RQ7: rotate right to accumulator: wrapped right rotate into accumulator, flags kept.
// RQ8: eight-bit operand, bits 0 to 7, done in one execution slot.
`timescale 1ns/1ps
module byte_rotate_unit
	import rotate_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic opValid,
	input wire rotOp_t opCode,
	input wire logic [7:0] memData,
	input wire logic carryIn,
	output logic [7:0] memWriteData,
	output logic memWrite,
	output logic [7:0] accData,
	output logic accWrite,
	output logic carryOut,
	output logic carryWrite
);
	// ==========================================
	// decode
	logic toLeft;
	logic viaCarry;
	logic toAcc;
	logic known;
	logic fillBit;
	logic [7:0] rotated;
	logic outBit;

	always_comb begin
		toLeft = 1'b0;
		viaCarry = 1'b0;
		toAcc = 1'b0;
		known = 1'b1;
		case (opCode)
			OP_ROTATE_LEFT_IN_PLACE: begin
				toLeft = 1'b1;
			end
			OP_ROTATE_LEFT_TO_ACCUMULATOR: begin
				toLeft = 1'b1;
				toAcc = 1'b1;
			end
			OP_ROTATE_LEFT_VIA_CARRY_IN_PLACE: begin
				toLeft = 1'b1;
				viaCarry = 1'b1;
			end
			OP_ROTATE_LEFT_VIA_CARRY_TO_ACCUMULATOR: begin
				toLeft = 1'b1;
				viaCarry = 1'b1;
				toAcc = 1'b1;
			end
			OP_ROTATE_RIGHT_IN_PLACE: begin
				toLeft = 1'b0;
			end
			OP_ROTATE_RIGHT_TO_ACCUMULATOR: begin
				toAcc = 1'b1;
			end
			// OP_NONE and the unused eighth code land here on purpose: no strobe at all
			default: begin
				known = 1'b0;
			end
		endcase
	end

	// wrap bit comes from the far end; carry forms use carryIn instead
	always_comb begin
		if (viaCarry)
			fillBit = carryIn; // RQ4 RQ5
		else if (toLeft)
			fillBit = memData[TOP_BIT]; // RQ1 RQ2
		else
			fillBit = memData[BOTTOM_BIT]; // RQ6 RQ7
	end

	rotate_shifter shifter (
		.operand(memData),
		.toLeft(toLeft),
		.fillBit(fillBit),
		.rotated(rotated),
		.outBit(outBit)
	); // RQ8

	// ==========================================
	// result registers
	logic [7:0] next_memWriteData;
	logic next_memWrite;
	logic [7:0] next_accData;
	logic next_accWrite;
	logic next_carryOut;
	logic next_carryWrite;

	// strobes default low so each result stands exactly one cycle
	always_comb begin
		next_memWriteData = memWriteData;
		next_accData = accData;
		next_carryOut = carryOut;
		next_memWrite = 1'b0;
		next_accWrite = 1'b0;
		next_carryWrite = 1'b0;
		if (opValid && known) begin
			if (toAcc) begin
				next_accData = rotated; // RQ2 RQ5 RQ7
				next_accWrite = 1'b1; // RQ3
			end else begin
				next_memWriteData = rotated; // RQ1 RQ4 RQ6
				next_memWrite = 1'b1;
			end
			// only carry forms touch a flag
			if (viaCarry) begin
				next_carryOut = outBit; // RQ4 RQ5
				next_carryWrite = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			memWriteData <= DATA_RESET;
			memWrite <= 1'b0;
			accData <= DATA_RESET;
			accWrite <= 1'b0;
			carryOut <= CARRY_RESET;
			carryWrite <= 1'b0;
		end else begin
			memWriteData <= next_memWriteData;
			memWrite <= next_memWrite;
			accData <= next_accData;
			accWrite <= next_accWrite;
			carryOut <= next_carryOut;
			carryWrite <= next_carryWrite;
		end
	end

	// ==========================================
	// checks
	// expectations are rebuilt from the sampled operand, never from the shifter
	a_left_wrap_mem: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ1
		opValid && opCode == OP_ROTATE_LEFT_IN_PLACE
		|=> memWrite && !accWrite && !carryWrite
		&& memWriteData == {$past(memData[TOP_BIT-1:BOTTOM_BIT]), $past(memData[TOP_BIT])})
		else $error("left rotate in place wrong");

	a_left_wrap_acc: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ2
		opValid && opCode == OP_ROTATE_LEFT_TO_ACCUMULATOR
		|=> accWrite && !memWrite && !carryWrite
		&& accData == {$past(memData[TOP_BIT-1:BOTTOM_BIT]), $past(memData[TOP_BIT])})
		else $error("left rotate to accumulator wrong");

	a_acc_no_mem: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ3
		accWrite |-> !memWrite)
		else $error("memory written by accumulator form");

	a_left_carry_mem: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ4
		opValid && opCode == OP_ROTATE_LEFT_VIA_CARRY_IN_PLACE
		|=> memWrite && !accWrite && carryWrite
		&& memWriteData == {$past(memData[TOP_BIT-1:BOTTOM_BIT]), $past(carryIn)}
		&& carryOut == $past(memData[TOP_BIT]))
		else $error("left via carry in place wrong");

	a_left_carry_acc: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ5
		opValid && opCode == OP_ROTATE_LEFT_VIA_CARRY_TO_ACCUMULATOR
		|=> accWrite && !memWrite && carryWrite
		&& accData == {$past(memData[TOP_BIT-1:BOTTOM_BIT]), $past(carryIn)}
		&& carryOut == $past(memData[TOP_BIT]))
		else $error("left via carry to accumulator wrong");

	a_right_wrap_mem: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ6
		opValid && opCode == OP_ROTATE_RIGHT_IN_PLACE
		|=> memWrite && !accWrite && !carryWrite
		&& memWriteData == {$past(memData[BOTTOM_BIT]), $past(memData[TOP_BIT:BOTTOM_BIT+1])})
		else $error("right rotate in place wrong");

	a_right_wrap_acc: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ7
		opValid && opCode == OP_ROTATE_RIGHT_TO_ACCUMULATOR
		|=> accWrite && !memWrite && !carryWrite
		&& accData == {$past(memData[BOTTOM_BIT]), $past(memData[TOP_BIT:BOTTOM_BIT+1])})
		else $error("right rotate to accumulator wrong");

	a_one_slot: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ8
		(memWrite || accWrite) |-> $past(opValid))
		else $error("result without request one cycle before");

	a_slot_answered: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ8
		opValid && known |=> memWrite != accWrite)
		else $error("taken request gave no single result");

	// idle cycles and ignored codes must leave every strobe low
	a_idle_quiet: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ8
		!opValid |=> !memWrite && !accWrite && !carryWrite)
		else $error("strobe without a request");

	a_none_quiet: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ8
		opValid && opCode == OP_NONE |=> !memWrite && !accWrite && !carryWrite)
		else $error("strobe for an ignored code");

	a_carry_held: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ1
		!carryWrite |-> $stable(carryOut))
		else $error("carry moved without a carry form");

	a_carry_with_result: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ5
		carryWrite |-> memWrite || accWrite)
		else $error("carry written without a result");

	// data outputs keep their last result so the core may read them late
	a_mem_data_held: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ3
		!memWrite |-> $stable(memWriteData))
		else $error("memory result moved without a write");

	a_acc_data_held: assert property (@(posedge core_clk) disable iff (!rst_n) // RQ6
		!accWrite |-> $stable(accData))
		else $error("accumulator result moved without a write");

endmodule // byte_rotate_unit

/* File: tb.sv */
// testbench for byte_rotate_unit: one task per scenario, self-checking
// assumes one 100 MHz clock and results one cycle after a taken request
`timescale 1ns/1ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin errCount++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb
	import rotate_pkg::*;
;
	logic core_clk, rst_n, opValid, carryIn;
	rotOp_t opCode;
	logic [7:0] memData, memWriteData, accData;
	logic memWrite, accWrite, carryOut, carryWrite;
	int errCount = 0;
	int samplesChecked = 0;
	int cycles = 0;

	byte_rotate_unit u_dut (.core_clk(core_clk), .rst_n(rst_n), .opValid(opValid), .opCode(opCode),
		.memData(memData), .carryIn(carryIn), .memWriteData(memWriteData), .memWrite(memWrite),
		.accData(accData), .accWrite(accWrite), .carryOut(carryOut), .carryWrite(carryWrite));

	// ==========================================
	// clock, timeout, closing
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// whole run needs well under a hundred cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			errCount++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d errors %0d", samplesChecked, errCount);
		if (errCount == 0 && samplesChecked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================
	// drivers: inputs change 1 ns after the edge
	task automatic put(rotOp_t o, logic [7:0] d, logic c);
		opValid = 1'b1;
		opCode = o;
		memData = d;
		carryIn = c;
		@(posedge core_clk);
		#1;
	endtask
	task automatic idle();
		opValid = 1'b0;
		opCode = OP_NONE;
		@(posedge core_clk);
		#1;
	endtask
	// strobes stand one cycle, so they are judged right after the answering edge
	task automatic see(logic mw, logic aw, logic cw, logic [7:0] v, logic co);
		`CHK(memWrite, mw)
		`CHK(accWrite, aw)
		`CHK(carryWrite, cw)
		if (mw) `CHK(memWriteData, v)
		if (aw) `CHK(accData, v)
		if (cw) `CHK(carryOut, co)
	endtask

	// ==========================================
	// scenarios
	task automatic tLeft();
		put(OP_ROTATE_LEFT_IN_PLACE, 8'h81, 1'b1);
		see(1'b1, 1'b0, 1'b0, 8'h03, 1'b0);
		put(OP_ROTATE_LEFT_TO_ACCUMULATOR, 8'h81, 1'b1);
		see(1'b0, 1'b1, 1'b0, 8'h03, 1'b0);
		`CHK(memWriteData, 8'h03)
	endtask
	task automatic tCarry();
		put(OP_ROTATE_LEFT_VIA_CARRY_IN_PLACE, 8'h81, 1'b0);
		see(1'b1, 1'b0, 1'b1, 8'h02, 1'b1);
		put(OP_ROTATE_LEFT_VIA_CARRY_IN_PLACE, 8'h40, 1'b1);
		see(1'b1, 1'b0, 1'b1, 8'h81, 1'b0);
		put(OP_ROTATE_LEFT_VIA_CARRY_TO_ACCUMULATOR, 8'h7f, 1'b1);
		see(1'b0, 1'b1, 1'b1, 8'hff, 1'b0);
	endtask
	task automatic tRight();
		put(OP_ROTATE_RIGHT_IN_PLACE, 8'h01, 1'b1);
		see(1'b1, 1'b0, 1'b0, 8'h80, 1'b0);
		put(OP_ROTATE_RIGHT_TO_ACCUMULATOR, 8'h02, 1'b0);
		see(1'b0, 1'b1, 1'b0, 8'h01, 1'b0);
		idle();
		see(1'b0, 1'b0, 1'b0, 8'h00, 1'b0);
	endtask
	task automatic tIgnored();
		put(OP_NONE, 8'h55, 1'b1);
		see(1'b0, 1'b0, 1'b0, 8'h00, 1'b0);
		idle();
	endtask
	// reset in mid-run clears held results; first request after release is taken
	task automatic tReset();
		put(OP_ROTATE_LEFT_VIA_CARRY_TO_ACCUMULATOR, 8'hc0, 1'b1);
		see(1'b0, 1'b1, 1'b1, 8'h81, 1'b1);
		opValid = 1'b0;
		opCode = OP_NONE;
		rst_n = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		`CHK(accData, DATA_RESET)
		`CHK(memWriteData, DATA_RESET)
		`CHK(carryOut, CARRY_RESET)
		rst_n = 1'b1;
		put(OP_ROTATE_RIGHT_IN_PLACE, 8'h80, 1'b1);
		see(1'b1, 1'b0, 1'b0, 8'h40, 1'b0);
		idle();
	endtask

	initial begin
		rst_n = 1'b0;
		opValid = 1'b0;
		opCode = OP_NONE;
		memData = 8'h00;
		carryIn = 1'b0;
		repeat (12) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		see(1'b0, 1'b0, 1'b0, 8'h00, 1'b0);
		tLeft();
		tCarry();
		tRight();
		tIgnored();
		tReset();
		summarize();
	end
endmodule // tb
